// ---- rtl/eeprom_consts.svh ----
// constants for the two-wire serial eeprom: sizes, field positions, timing
// assumes a 100 MHz system clock and a controller-driven serial clock
`ifndef EEPROM_CONSTS_SVH
`define EEPROM_CONSTS_SVH

// ==========================================================
// array and bus shape
`define MEM_WORDS 128
`define ADDR_W 7
`define PAGE_BYTES 4
`define BIT_LAST 3'h7
`define BIT_FIRST 3'h0
`define BIT_STEP 3'h1
`define ADDR_STEP 7'h01
`define LOW_STEP 2'h1
`define DIR_READ 1'h1

// ==========================================================
// timing: times in ms, clock rate in kHz
`define SYS_CLK_KHZ 100000
`define WR_CYCLE_TYP_MS 5
`define WR_CYCLE_MAX_MS 10
`define POWER_UP_TO_READ_DELAY_MS 1
`define POWER_UP_TO_WRITE_DELAY_MS 5
`define WR_TIMER_W 20

`endif

// ---- rtl/eeprom_pkg.sv ----
// types shared by the eeprom protocol engine and its data-line stage
// assumes the constants header is on the include path
`include "eeprom_consts.svh"

package eeprom_pkg;

    // ==========================================================
    // protocol states, gray coded along the usual path
    typedef enum logic [2:0] {
        ST_IDLE      = 3'h0,
        ST_ADDR      = 3'h1,
        ST_ADDR_ACK  = 3'h3,
        ST_WDATA     = 3'h2,
        ST_WACK      = 3'h6,
        ST_RDATA     = 3'h7,
        ST_RACK      = 3'h5,
        ST_WAIT_STOP = 3'h4
    } proto_state_t;

    // ==========================================================
    // whole state of the protocol engine
    typedef struct packed {
        logic scl_s1;
        logic scl_s2;
        logic scl_p;
        logic sda_s1;
        logic sda_s2;
        logic sda_p;
        proto_state_t st;
        logic [2:0] cnt;
        logic [7:0] shreg;
        logic [`ADDR_W-1:0] addr;
        logic rw;
        logic want_low;
        logic closed;
        logic en;
        logic busy;
        logic [`WR_TIMER_W-1:0] timer;
        logic [`PAGE_BYTES-1:0][7:0] page;
        logic [`PAGE_BYTES-1:0] pend;
        logic [`MEM_WORDS-1:0][7:0] mem;
    } engine_state_t;

    // state of the serial-clock data-line stage
    typedef struct packed {
        logic pull_low;
    } link_state_t;

endpackage

// ---- rtl/sda_drive_stage.sv ----
// data-line stage on the serial clock: takes the wanted level at each falling edge
// assumes want_low has settled by the end of the serial clock high phase and is steady at each falling edge
`timescale 1ns/1ps

module sda_drive_stage (
    // serial clock from the controller
    input wire logic scl_clk,
    // level from the system domain
    input wire logic want_low,
    // registered pull request
    output logic pull_low
);
    eeprom_pkg::link_state_t q;
    eeprom_pkg::link_state_t d;

    // ==========================================================
    // next state: change only while the serial clock is low
    always_comb begin
        d = q;
        d.pull_low = want_low;
    end

    // register on the falling serial clock edge
    always_ff @(negedge scl_clk) begin
        q <= d;
    end

    assign pull_low = q.pull_low;
endmodule // sda_drive_stage

// ---- rtl/two_wire_eeprom.sv ----
// protocol engine of a 128 x 8 two-wire serial eeprom without device select
// assumes clock at 100 MHz; scl and sda are pins from a controller-driven bus
//
// Overview of operation
// R1: internal write lasts at most 10 ms after the stop; controller waits or polls
// R2: while writing, device ignores address, releases data line, interface disabled
// R3: device only pulls the data line low or releases it, never drives high
// R4: data line changes only while clock low; high-phase changes mean start/stop
// R5: start is data falling with clock high; device ignores traffic until one
// R6: a new start is honoured only after a stop closed the previous sequence
// R7: stop is data rising with clock high; ends transfer, returns to standby
// R8: controller issues a stop only after the transmitter released the line
// R9: transmitter releases after eight bits; receiver pulls low in ninth clock
// R10: device acknowledges the address byte and every received write data byte
// R11: reading, device sends eight bits, samples acknowledge, continues or awaits stop
// R12: byte write is start, address plus write bit, data, stop, then internal write
// R13: upper five address bits pick a page; up to four bytes acknowledged; the engine acknowledges every further byte too
// R14: write steps only two low address bits; overflow wraps inside the page
// R15: polling start plus address gets no acknowledge until the write completes
// R16: controller ends a read by stop in ninth clock or no acknowledge then stop
// R17: byte read is start, address plus read bit, acknowledge, eight data bits
// R18: sequential read steps all address bits and wraps from top to zero
// R19: controller waits up to 1 ms before reading and 5 ms before writing
// R20: bytes go msb first; direction bit last, one means read
`timescale 1ns/1ps
`include "eeprom_consts.svh"

module two_wire_eeprom #(
    parameter int unsigned WR_CYCLES = `WR_CYCLE_TYP_MS * `SYS_CLK_KHZ
) (
    // system clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // two-wire bus: serial clock, data line split into in, out, enable
    input wire logic scl_clk,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    // status
    output logic busy,
    output logic standby
);
    localparam int unsigned WR_MAX = `WR_CYCLE_MAX_MS * `SYS_CLK_KHZ;
    localparam logic [`WR_TIMER_W-1:0] WR_LAST = (`WR_TIMER_W)'(WR_CYCLES - 1);

    // ==========================================================
    // elaboration check
    if (WR_CYCLES < 1 || WR_CYCLES > WR_MAX || WR_CYCLES >= (1 << `WR_TIMER_W)) begin : g_chk
        $error("WR_CYCLES out of range");
    end

    eeprom_pkg::engine_state_t q;
    eeprom_pkg::engine_state_t d;
    logic scl_rise;
    logic start_evt;
    logic stop_evt;
    logic [7:0] in_byte;
    logic pull_low;

    // ==========================================================
    // bus events from the synchronised lines
    assign scl_rise = q.scl_s2 & ~q.scl_p;
    assign start_evt = q.scl_s2 & q.scl_p & q.sda_p & ~q.sda_s2; // see R5
    assign stop_evt = q.scl_s2 & q.scl_p & ~q.sda_p & q.sda_s2; // see R7
    assign in_byte = {q.shreg[6:0], q.sda_s2}; // see R20

    // ==========================================================
    // next state
    always_comb begin
        d = q;
        // two-stage synchronisers plus one history stage
        d.scl_s1 = scl_clk;
        d.scl_s2 = q.scl_s1;
        d.scl_p = q.scl_s2;
        d.sda_s1 = sda_i;
        d.sda_s2 = q.sda_s1;
        d.sda_p = q.sda_s2;
        // drive stage holds a valid level once a falling edge has passed
        if (!q.scl_s2 && q.scl_p) begin
            d.en = 1'b1;
        end
        // self-timed internal write, then page commit
        if (q.busy) begin
            if (q.timer == WR_LAST) begin
                d.busy = 1'b0; // see R1
                d.timer = '0;
                d.pend = '0;
                for (int i = 0; i < `PAGE_BYTES; i++) begin
                    if (q.pend[i]) begin
                        d.mem[{q.addr[`ADDR_W-1:2], 2'(i)}] = q.page[i];
                    end
                end
            end else begin
                d.timer = q.timer + (`WR_TIMER_W)'(1);
            end
        end
        if (stop_evt) begin
            // stop closes any sequence and releases the line
            d.st = eeprom_pkg::ST_IDLE; // see R7
            d.want_low = 1'b0;
            d.closed = 1'b1;
            if (!q.busy && q.pend != '0) begin
                d.busy = 1'b1; // see R12
                d.timer = '0;
            end
        end else if (start_evt) begin
            if (q.closed) begin
                d.st = eeprom_pkg::ST_ADDR; // see R5
                d.cnt = `BIT_FIRST;
                d.closed = 1'b0;
                d.want_low = 1'b0;
            end else begin
                // unclosed sequence: drop it and wait for a stop
                d.st = eeprom_pkg::ST_WAIT_STOP; // see R6
                d.want_low = 1'b0;
                if (!q.busy) begin
                    d.pend = '0;
                end
            end
        end else if (scl_rise) begin
            case (q.st)
                eeprom_pkg::ST_ADDR: begin
                    d.shreg = in_byte;
                    d.cnt = q.cnt + `BIT_STEP;
                    if (q.cnt == `BIT_LAST) begin
                        if (q.busy) begin
                            // address ignored, no acknowledge while writing
                            d.st = eeprom_pkg::ST_WAIT_STOP; // see R2, R15
                            d.want_low = 1'b0;
                        end else begin
                            d.addr = in_byte[7:1];
                            d.rw = in_byte[0]; // see R20
                            d.want_low = 1'b1; // see R10
                            d.st = eeprom_pkg::ST_ADDR_ACK;
                        end
                    end
                end
                eeprom_pkg::ST_ADDR_ACK: begin
                    d.cnt = `BIT_FIRST;
                    if (q.rw == `DIR_READ) begin
                        d.shreg = q.mem[q.addr]; // see R17
                        d.want_low = ~q.mem[q.addr][7];
                        d.st = eeprom_pkg::ST_RDATA;
                    end else begin
                        d.want_low = 1'b0;
                        d.st = eeprom_pkg::ST_WDATA;
                    end
                end
                eeprom_pkg::ST_WDATA: begin
                    d.shreg = in_byte;
                    d.cnt = q.cnt + `BIT_STEP;
                    if (q.cnt == `BIT_LAST) begin
                        // latch into the page slot, step low bits only
                        d.page[q.addr[1:0]] = in_byte; // see R13
                        d.pend[q.addr[1:0]] = 1'b1;
                        d.addr[1:0] = q.addr[1:0] + `LOW_STEP; // see R14
                        d.want_low = 1'b1; // see R9, R10
                        d.st = eeprom_pkg::ST_WACK;
                    end
                end
                eeprom_pkg::ST_WACK: begin
                    d.want_low = 1'b0;
                    d.st = eeprom_pkg::ST_WDATA;
                end
                eeprom_pkg::ST_RDATA: begin
                    if (q.cnt == `BIT_LAST) begin
                        d.want_low = 1'b0; // see R9, R11
                        d.cnt = `BIT_FIRST;
                        d.st = eeprom_pkg::ST_RACK;
                    end else begin
                        d.shreg = {q.shreg[6:0], 1'b0};
                        d.want_low = ~q.shreg[6];
                        d.cnt = q.cnt + `BIT_STEP;
                    end
                end
                eeprom_pkg::ST_RACK: begin
                    if (!q.sda_s2) begin
                        // acknowledged: next byte, wrapping over the whole array
                        d.addr = q.addr + `ADDR_STEP; // see R18
                        d.shreg = q.mem[q.addr + `ADDR_STEP];
                        d.want_low = ~q.mem[q.addr + `ADDR_STEP][7];
                        d.st = eeprom_pkg::ST_RDATA; // see R11
                    end else begin
                        d.st = eeprom_pkg::ST_WAIT_STOP; // see R11, R16
                    end
                end
                eeprom_pkg::ST_IDLE, eeprom_pkg::ST_WAIT_STOP: begin
                    d.want_low = 1'b0;
                end
                default: begin
                    d.st = eeprom_pkg::ST_IDLE;
                    d.want_low = 1'b0;
                end
            endcase
        end
    end

    // state register with synchronous reset
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            q <= '0;
            q.closed <= 1'b1;
            // synchronisers start at the idle high level, so no false edge follows reset
            q.scl_s1 <= 1'b1;
            q.scl_s2 <= 1'b1;
            q.scl_p <= 1'b1;
            q.sda_s1 <= 1'b1;
            q.sda_s2 <= 1'b1;
            q.sda_p <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // ==========================================================
    // data line: changes only on the falling serial clock
    sda_drive_stage u_stage (
        .scl_clk(scl_clk),
        .want_low(q.want_low),
        .pull_low(pull_low)
    ); // see R4

    // open drain: output level fixed low, enable only pulls
    assign sda_o = 1'b0; // see R3
    assign sda_oe = pull_low & q.en;
    assign busy = q.busy;
    assign standby = (q.st == eeprom_pkg::ST_IDLE) & ~q.busy; // see R7

    // ==========================================================
    // checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    sequence addr_last_bit;
        scl_rise && !start_evt && !stop_evt && q.st == eeprom_pkg::ST_ADDR && q.cnt == `BIT_LAST;
    endsequence

    sequence read_last_bit;
        scl_rise && !start_evt && !stop_evt && q.st == eeprom_pkg::ST_RDATA && q.cnt == `BIT_LAST;
    endsequence

    sequence write_last_bit;
        scl_rise && !start_evt && !stop_evt && q.st == eeprom_pkg::ST_WDATA && q.cnt == `BIT_LAST;
    endsequence

    busy_releases_line_a: assert property (q.busy |-> !q.want_low) // see R2
        else $error("line pulled during internal write");
    start_opens_addr_a: assert property (start_evt && !stop_evt && q.closed |=>
        q.st == eeprom_pkg::ST_ADDR && q.cnt == `BIT_FIRST) // see R5
        else $error("start did not open address phase");
    unclosed_start_a: assert property (start_evt && !stop_evt && !q.closed |=>
        q.st == eeprom_pkg::ST_WAIT_STOP) // see R6
        else $error("start honoured without prior stop");
    stop_to_idle_a: assert property (stop_evt |=> q.st == eeprom_pkg::ST_IDLE && q.closed) // see R7
        else $error("stop did not return to idle");
    addr_ack_a: assert property (addr_last_bit and (!q.busy) |=>
        q.want_low && q.st == eeprom_pkg::ST_ADDR_ACK && q.addr == $past(in_byte[7:1])) // see R10
        else $error("address byte not acknowledged");
    poll_no_ack_a: assert property (addr_last_bit and q.busy |=> !q.want_low [*2]) // see R15
        else $error("acknowledge given while busy");
    read_release_a: assert property (read_last_bit |=>
        !q.want_low && q.st == eeprom_pkg::ST_RACK) // see R11
        else $error("line not released for read acknowledge");
    page_wrap_a: assert property (scl_rise && !start_evt && !stop_evt && // see R14
        q.st == eeprom_pkg::ST_WDATA && q.cnt == `BIT_LAST |=>
        q.addr[6:2] == $past(q.addr[6:2]) && q.addr[1:0] == $past(q.addr[1:0]) + `LOW_STEP)
        else $error("write address left its page");
    seq_wrap_a: assert property (scl_rise && !start_evt && !stop_evt && // see R18
        q.st == eeprom_pkg::ST_RACK && !q.sda_s2 |=> q.addr == $past(q.addr) + `ADDR_STEP)
        else $error("read address did not step");
    write_time_a: assert property ($fell(q.busy) |-> $past(q.timer) == WR_LAST) // see R1
        else $error("internal write ended at wrong count");
    write_starts_a: assert property (stop_evt && !q.busy && q.pend != '0 |=>
        q.busy && q.timer == '0 ##1 q.busy) // see R12
        else $error("stop after data did not start write");

    // acknowledge, page slot, read-path and standby checks
    write_ack_a: assert property (write_last_bit |=> q.want_low && q.st == eeprom_pkg::ST_WACK) // see R10
        else $error("data byte not acknowledged");
    page_store_a: assert property (write_last_bit |=> q.pend[$past(q.addr[1:0])] && // see R13
        q.page[$past(q.addr[1:0])] == $past(in_byte))
        else $error("data byte not held in its page slot");
    ack_release_a: assert property (scl_rise && !start_evt && !stop_evt && // see R9
        q.st == eeprom_pkg::ST_WACK |=> !q.want_low && q.st == eeprom_pkg::ST_WDATA)
        else $error("line held after write acknowledge");
    read_load_a: assert property (scl_rise && !start_evt && !stop_evt && // see R17
        q.st == eeprom_pkg::ST_ADDR_ACK && q.rw == `DIR_READ |=>
        q.st == eeprom_pkg::ST_RDATA && q.shreg == $past(q.mem[q.addr]) &&
        q.want_low == ~q.shreg[7])
        else $error("read data not loaded after address");
    read_next_a: assert property (scl_rise && !start_evt && !stop_evt && // see R11
        q.st == eeprom_pkg::ST_RACK && !q.sda_s2 |=>
        q.st == eeprom_pkg::ST_RDATA && q.want_low == ~q.shreg[7])
        else $error("acknowledged read did not continue");
    noack_wait_a: assert property (scl_rise && !start_evt && !stop_evt && // see R11
        q.st == eeprom_pkg::ST_RACK && q.sda_s2 |=>
        q.st == eeprom_pkg::ST_WAIT_STOP && !q.want_low)
        else $error("read went on without acknowledge");
    idle_standby_a: assert property (stop_evt && !q.busy && q.pend == '0 |=> standby) // see R7
        else $error("stop did not return to standby");
    unclosed_drop_a: assert property (start_evt && !stop_evt && !q.closed && !q.busy |=> // see R6
        q.pend == '0)
        else $error("unclosed sequence kept page bytes");
    commit_clears_a: assert property ($fell(q.busy) |-> q.pend == '0) // see R1
        else $error("page bytes left pending after write");
endmodule // two_wire_eeprom

// ---- verification/two_wire_ctrl_model.sv ----
// controller model of the two-wire bus: makes the serial clock, pulls the data line
// assumes a pull-up on the data line; the bench resolves the wired level
`timescale 1ns/1ps

module two_wire_ctrl_model (
    // resolved data line
    input wire logic sda_line,
    // serial clock and data pull-down
    output logic scl_clk,
    output logic pull_low
);
    // ==========================================================
    // idle bus: clock parked high between frames, data released
    initial begin
        scl_clk = 1'b1;
        pull_low = 1'b0;
    end

    // ==========================================================
    // frame conditions
    // start, also a repeated start from a low clock
    task automatic send_start();
        #20 pull_low = 1'b0;
        #20 scl_clk = 1'b1;
        #20 pull_low = 1'b1;
        #20 scl_clk = 1'b0;
    endtask

    // stop, issued once the transmitter has let go of the line
    task automatic send_stop();
        #20 pull_low = 1'b1;
        #20 scl_clk = 1'b1;
        #20 pull_low = 1'b0;
        #20;
    endtask

    // ==========================================================
    // one clock pulse; data moves only while the clock is low
    task automatic clock_bit(input logic b, output logic seen);
        #20 pull_low = ~b;
        #20 scl_clk = 1'b1;
        #20 seen = sda_line;
        #20 scl_clk = 1'b0;
    endtask

    // byte out msb first, then release for the acknowledge
    task automatic put_byte(input logic [7:0] v, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) clock_bit(v[i], s);
        clock_bit(1'b1, s);
        ack = ~s;
    endtask

    // byte in msb first, then acknowledge or leave high to end the read
    task automatic get_byte(input logic ack, output logic [7:0] v);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clock_bit(1'b1, s);
            v[i] = s;
        end
        clock_bit(~ack, s);
    endtask
endmodule // two_wire_ctrl_model

// ---- verification/testbench.sv ----
// self-checking bench for the two-wire eeprom protocol engine
// assumes the design files and the controller model are compiled first
`timescale 1ns/1ps

module testbench;
    localparam int WR = 200;
    logic clock;
    logic rst_n;
    logic scl_clk;
    logic pull_low;
    logic sda_o;
    logic sda_oe;
    logic busy;
    logic standby;
    logic bad_level = 1'b0;
    logic bad_timing = 1'b0;
    wire logic sda_line;
    int n_errors;
    int tests_run;

    // ==========================================================
    // clock, wired-and data line with pull-up, design and controller
    always #5 clock = ~clock;
    assign sda_line = (sda_oe === 1'b1 ? sda_o : 1'b1) & ~pull_low;

    two_wire_eeprom #(.WR_CYCLES(WR)) u_two_wire_eeprom (.clock(clock), .rst_n(rst_n),
        .scl_clk(scl_clk), .sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe),
        .busy(busy), .standby(standby));
    two_wire_ctrl_model u_two_wire_ctrl_model (.sda_line(sda_line), .scl_clk(scl_clk),
        .pull_low(pull_low));

    // device may only pull low, and moves the line only with the clock low
    always @(posedge clock) if (rst_n && sda_oe === 1'b1 && sda_o !== 1'b0) bad_level <= 1'b1;
    always @(sda_oe) if (rst_n && scl_clk) bad_timing <= 1'b1;

    // ==========================================================
    // comparison, verdict and bounded wait
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("comparisons %0d, mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // wait for busy to reach a level; a spent bound ends the run
    task automatic wait_busy(input logic lvl, input int lim);
        int n;
        n = 0;
        while (busy !== lvl) begin
            @(posedge clock);
            #1;
            n++;
            if (n > lim) begin
                n_errors++;
                $display("unexpected at %0t: busy stuck", $time);
                report_and_stop();
            end
        end
    endtask

    // ==========================================================
    // transfer helpers
    task automatic addr_phase(input logic [6:0] a, input logic rd, input logic exp_ack);
        logic ack;
        u_two_wire_ctrl_model.send_start();
        u_two_wire_ctrl_model.put_byte({a, rd}, ack);
        check(ack, exp_ack);
    endtask

    // page write; returns once the internal write has begun
    task automatic write_page(input logic [6:0] a, input logic [7:0] d [$]);
        logic ack;
        addr_phase(a, 1'b0, 1'b1);
        foreach (d[i]) begin
            u_two_wire_ctrl_model.put_byte(d[i], ack);
            check(ack, 1'b1);
        end
        u_two_wire_ctrl_model.send_stop();
        wait_busy(1'b1, 10);
        check(standby, 1'b0);
    endtask

    // sequential read, no-ack at the end, then one more byte that must float
    task automatic read_check(input logic [6:0] a, input logic [7:0] e [$]);
        logic [7:0] v;
        addr_phase(a, 1'b1, 1'b1);
        foreach (e[i]) begin
            u_two_wire_ctrl_model.get_byte(i < e.size() - 1, v);
            check(v, e[i]);
        end
        u_two_wire_ctrl_model.get_byte(1'b0, v);
        check(v, 8'hff);
        u_two_wire_ctrl_model.send_stop();
        repeat (8) @(posedge clock);
        #1;
        check(standby, 1'b1);
    endtask

    // ==========================================================
    // scenarios
    task automatic test_write_poll();
        write_page(7'h00, '{8'ha5});
        addr_phase(7'h33, 1'b0, 1'b0);
        u_two_wire_ctrl_model.send_stop();
        wait_busy(1'b0, 2 * WR);
        read_check(7'h00, '{8'ha5});
        $display("write with polling done");
    endtask

    task automatic test_page_wrap();
        write_page(7'h0e, '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55});
        wait_busy(1'b0, 2 * WR);
        read_check(7'h0c, '{8'h33, 8'h44, 8'h55, 8'h22, 8'h00});
        $display("page wrap done");
    endtask

    // read ended by a stop inside the ninth clock
    task automatic test_stop_in_ack();
        logic [7:0] v;
        logic s;
        addr_phase(7'h0c, 1'b1, 1'b1);
        for (int i = 7; i >= 0; i--) begin
            u_two_wire_ctrl_model.clock_bit(1'b1, s);
            v[i] = s;
        end
        check(v, 8'h33);
        u_two_wire_ctrl_model.send_stop();
        repeat (8) @(posedge clock);
        #1;
        check(standby, 1'b1);
        $display("stop in ninth clock done");
    endtask

    task automatic test_read_wrap();
        write_page(7'h7f, '{8'h5a});
        wait_busy(1'b0, 2 * WR);
        read_check(7'h7f, '{8'h5a, 8'ha5});
        $display("read wrap done");
    endtask

    task automatic test_no_stop();
        logic ack;
        addr_phase(7'h20, 1'b0, 1'b1);
        u_two_wire_ctrl_model.put_byte(8'h77, ack);
        addr_phase(7'h20, 1'b0, 1'b0);
        u_two_wire_ctrl_model.send_stop();
        repeat (20) @(posedge clock);
        #1;
        check(busy, 1'b0);
        read_check(7'h20, '{8'h00});
        $display("start without stop done");
    endtask

    // ==========================================================
    // reset, scenarios, verdict
    initial begin
        clock = 1'b0;
        rst_n = 1'b0;
        n_errors = 0;
        tests_run = 0;
        repeat (12) @(posedge clock);
        rst_n <= 1'b1;
        repeat (4) @(posedge clock); // the design needs no power-up wait
        #3;
        test_write_poll();
        test_page_wrap();
        test_stop_in_ack();
        test_read_wrap();
        test_no_stop();
        check(bad_level, 1'b0);
        check(bad_timing, 1'b0);
        report_and_stop();
    end
endmodule // testbench
